/* common/virq_defines.vh */
// Purpose: Constants for the virtual interrupt completion block
// Assumes: APB byte addresses, 32-bit words, four list entries
// Notes: Entry layout and all offsets are fixed here; the test's le() function repeats the entry layout
//
// Summary of operation
// - Four list entries hold the pending and active virtual interrupts.
// - Guest acknowledge, completion and deactivate accesses update list entries.
// - Deactivating a hardware-linked entry forwards deactivation to the distributor.
// - Completion naming an interrupt absent from every entry changes no entry.
// - Hardware-linked entries never hold active and pending together.
// - Guest sees a pending interrupt only when a list entry holds it.
// - Physical split mode set: hypervisor completion only drops running priority.
// - After priority drop, the lowered running priority gates new physical interrupts.
// - Dropped but undeactivated physical interrupt stays active, never re-signalled.
// - Virtual split clear, hardware-linked: guest completion deactivates both interrupts.
// - Virtual split set: only the guest deactivate write deactivates.
`ifndef VIRQ_DEFINES_VH
`define VIRQ_DEFINES_VH

`define ADDR_W 12
`define LE_COUNT 4
`define OFS_LE0 12'h000
`define OFS_LE1 12'h004
`define OFS_LE2 12'h008
`define OFS_LE3 12'h00C
`define OFS_VCTRL 12'h010
`define OFS_PCTRL 12'h014
`define OFS_VACK 12'h018
`define OFS_VEOI 12'h01C
`define OFS_VAEOI 12'h020
`define OFS_VDIR 12'h024
`define OFS_PACK 12'h028
`define OFS_PEOI 12'h02C
`define OFS_PAEOI 12'h030
`define OFS_PDIR 12'h034
`define OFS_STATUS 12'h038

`define LE_VID_LSB 0
`define LE_PID_LSB 10
`define LE_PRIO_LSB 23
`define LE_PEND_BIT 28
`define LE_ACT_BIT 29
`define LE_HW_BIT 31
`define LE_RST 32'h00000000

`define CTRL_EN_BIT 0
`define CTRL_SPLIT_BIT 9
`define CTRL_RST 10'h000

`define ST_MISS_BIT 0
`define ST_VPEND_BIT 1
`define ST_PACT_LSB 4
`define ST_PDROP_LSB 8

`define ID_SPURIOUS 10'h3FF
`define PRIO_IDLE 5'h1F

`endif

/* rtl/virq_completion.v */
// Purpose: List entries, guest completion and physical priority drop
// Assumes: Inputs synchronous to core_clk_in; one APB transfer at a time
// Notes: Alias completion registers act like the plain ones
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "virq_defines.vh"

module virq_completion (
  input wire core_clk_in,
  input wire resetn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  input wire phys_irq_req_in,
  input wire [9:0] phys_irq_id_in,
  input wire [4:0] phys_irq_prio_in,
  output wire phys_irq_out,
  output wire virt_irq_out,
  output wire dist_deact_out,
  output wire [9:0] dist_deact_id_out
);

////////////////////////////////////////////////////////////////////////
// Lookup helpers

  // Lowest index wins so duplicate entries resolve predictably
  function [2:0] find_virt;
    input [9:0] id;
    input [127:0] flat;
    integer k;
    begin
      find_virt = 3'h0;
      for (k = 3; k >= 0; k = k - 1) begin
        if (flat[k*32+`LE_ACT_BIT] && flat[k*32+`LE_VID_LSB +: 10] == id) begin
          find_virt = {1'b1, k[1:0]};
        end
      end
    end
  endfunction

  function [2:0] find_phys;
    input [9:0] id;
    input [39:0] ids;
    input [3:0] mask;
    integer k;
    begin
      find_phys = 3'h0;
      for (k = 3; k >= 0; k = k - 1) begin
        if (mask[k] && ids[k*10 +: 10] == id) begin
          find_phys = {1'b1, k[1:0]};
        end
      end
    end
  endfunction

////////////////////////////////////////////////////////////////////////
// State

  reg [31:0] le_q [0:3];
  reg [9:0] vctrl_q;
  reg [9:0] pctrl_q;
  reg [9:0] ps_id_q [0:3];
  reg [4:0] ps_prio_q [0:3];
  reg [3:0] ps_act_q;
  reg [3:0] ps_drop_q;
  reg miss_q;
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg ack_ok_q;
  reg [1:0] ack_idx_q;
  reg [4:0] ack_prio_q;
  reg virt_irq_q;
  reg phys_irq_q;
  reg dist_deact_q;
  reg [9:0] dist_deact_id_q;

  wire acc = psel_in & penable_in;
  wire setup_edge = acc & ~pready_q;
  wire done = acc & pready_q;
  wire [127:0] le_flat = {le_q[3], le_q[2], le_q[1], le_q[0]};
  wire [39:0] ps_ids = {ps_id_q[3], ps_id_q[2], ps_id_q[1], ps_id_q[0]};
  wire vsplit = vctrl_q[`CTRL_SPLIT_BIT];
  wire psplit = pctrl_q[`CTRL_SPLIT_BIT];
  wire [2:0] ve = find_virt(pwdata_in[9:0], le_flat);
  wire [31:0] ve_ent = le_q[ve[1:0]];
  wire [9:0] ve_pid = ve_ent[`LE_PID_LSB +: 10];
  wire [2:0] pe_live = find_phys(pwdata_in[9:0], ps_ids, ps_act_q & ~ps_drop_q);
  wire [2:0] pe_any = find_phys(pwdata_in[9:0], ps_ids, ps_act_q);
  wire [2:0] pe_fwd = find_phys(ve_pid, ps_ids, ps_act_q);
  wire [2:0] pe_busy = find_phys(phys_irq_id_in, ps_ids, ps_act_q);

////////////////////////////////////////////////////////////////////////
// Combinational search

  reg vp_found;
  reg [1:0] vp_idx;
  reg free_found;
  reg [1:0] free_idx;
  reg [4:0] run_prio;
  reg phys_sig;
  integer i;
  // Separate index for the clocked loop; sharing i would give it two drivers
  integer j;

  always @* begin
    vp_found = 1'b0;
    vp_idx = 2'h0;
    free_found = 1'b0;
    free_idx = 2'h0;
    run_prio = `PRIO_IDLE;
    for (i = 3; i >= 0; i = i - 1) begin
      // Only listed entries are candidates for the guest
      if (le_q[i][`LE_PEND_BIT] && !le_q[i][`LE_ACT_BIT]) begin
        vp_found = 1'b1;
        vp_idx = i[1:0];
      end
      if (!ps_act_q[i]) begin
        free_found = 1'b1;
        free_idx = i[1:0];
      end
      // Dropped slots no longer hold the running priority
      if (ps_act_q[i] && !ps_drop_q[i] && ps_prio_q[i] < run_prio) begin
        run_prio = ps_prio_q[i];
      end
    end
    // An active (even dropped) identifier is never signalled again
    phys_sig = pctrl_q[`CTRL_EN_BIT] & phys_irq_req_in & ~pe_busy[2] &
               free_found & (phys_irq_prio_in < run_prio);
  end

////////////////////////////////////////////////////////////////////////
// APB answer: pready rises one cycle into the access phase

  reg [31:0] rd_d;
  reg err_d;

  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (paddr_in)
      `OFS_LE0, `OFS_LE1, `OFS_LE2, `OFS_LE3: begin
        rd_d = le_q[paddr_in[3:2]];
      end
      `OFS_VCTRL: begin
        rd_d = {22'h000000, vctrl_q};
      end
      `OFS_PCTRL: begin
        rd_d = {22'h000000, pctrl_q};
      end
      `OFS_VACK: begin
        if (vp_found && vctrl_q[`CTRL_EN_BIT]) begin
          rd_d = {22'h000000, le_q[vp_idx][`LE_VID_LSB +: 10]};
        end else begin
          rd_d = {22'h000000, `ID_SPURIOUS};
        end
      end
      `OFS_PACK: begin
        rd_d = {22'h000000, phys_sig ? phys_irq_id_in : `ID_SPURIOUS};
      end
      `OFS_STATUS: begin
        rd_d[`ST_MISS_BIT] = miss_q;
        rd_d[`ST_VPEND_BIT] = vp_found;
        rd_d[`ST_PACT_LSB +: 4] = ps_act_q;
        rd_d[`ST_PDROP_LSB +: 4] = ps_drop_q;
      end
      `OFS_VEOI, `OFS_VAEOI, `OFS_VDIR, `OFS_PEOI, `OFS_PAEOI, `OFS_PDIR: begin
        rd_d = 32'h00000000;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      ack_ok_q <= 1'b0;
      ack_idx_q <= 2'h0;
      ack_prio_q <= `PRIO_IDLE;
    end else begin
      pready_q <= setup_edge;
      if (setup_edge) begin
        prdata_q <= pwrite_in ? 32'h00000000 : rd_d;
        pslverr_q <= err_d;
        // Acknowledge choice is frozen here so the read data and the
        // state change at completion always agree
        if (paddr_in == `OFS_VACK) begin
          ack_ok_q <= vp_found & vctrl_q[`CTRL_EN_BIT];
          ack_idx_q <= vp_idx;
        end else begin
          ack_ok_q <= phys_sig;
          ack_idx_q <= free_idx;
          ack_prio_q <= phys_irq_prio_in;
        end
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// Register effects, taken at the completing edge only

  reg [31:0] wr_le;

  always @* begin
    wr_le = pwdata_in;
    // Combined state is for hypervisor-made entries only
    if (wr_le[`LE_HW_BIT] && wr_le[`LE_ACT_BIT]) begin
      wr_le[`LE_PEND_BIT] = 1'b0;
    end
  end

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      for (j = 0; j < 4; j = j + 1) begin
        le_q[j] <= `LE_RST;
        ps_id_q[j] <= 10'h000;
        ps_prio_q[j] <= `PRIO_IDLE;
      end
      vctrl_q <= `CTRL_RST;
      pctrl_q <= `CTRL_RST;
      ps_act_q <= 4'h0;
      ps_drop_q <= 4'h0;
      miss_q <= 1'b0;
      dist_deact_q <= 1'b0;
      dist_deact_id_q <= 10'h000;
    end else begin
      dist_deact_q <= 1'b0;
      if (done && pwrite_in) begin
        case (paddr_in)
          `OFS_LE0, `OFS_LE1, `OFS_LE2, `OFS_LE3: begin
            le_q[paddr_in[3:2]] <= wr_le;
          end
          `OFS_VCTRL: begin
            vctrl_q <= pwdata_in[9:0];
          end
          `OFS_PCTRL: begin
            pctrl_q <= pwdata_in[9:0];
          end
          `OFS_VEOI, `OFS_VAEOI: begin
            if (ve[2]) begin
              // Split mode leaves the entry active for a later deactivate
              if (!vsplit) begin
                le_q[ve[1:0]][`LE_ACT_BIT] <= 1'b0;
                if (ve_ent[`LE_HW_BIT]) begin
                  dist_deact_q <= 1'b1;
                  dist_deact_id_q <= ve_pid;
                  if (pe_fwd[2]) begin
                    ps_act_q[pe_fwd[1:0]] <= 1'b0;
                    ps_drop_q[pe_fwd[1:0]] <= 1'b0;
                  end
                end
              end
            end else begin
              // No entry touched; only the sticky miss flag records it
              miss_q <= 1'b1;
            end
          end
          `OFS_VDIR: begin
            if (ve[2] && vsplit) begin
              le_q[ve[1:0]][`LE_ACT_BIT] <= 1'b0;
              // Entries without the link leave the physical side alone
              if (ve_ent[`LE_HW_BIT]) begin
                dist_deact_q <= 1'b1;
                dist_deact_id_q <= ve_pid;
                if (pe_fwd[2]) begin
                  ps_act_q[pe_fwd[1:0]] <= 1'b0;
                  ps_drop_q[pe_fwd[1:0]] <= 1'b0;
                end
              end
            end
          end
          `OFS_PEOI, `OFS_PAEOI: begin
            if (pe_live[2]) begin
              if (psplit) begin
                ps_drop_q[pe_live[1:0]] <= 1'b1;
              end else begin
                ps_act_q[pe_live[1:0]] <= 1'b0;
                dist_deact_q <= 1'b1;
                dist_deact_id_q <= pwdata_in[9:0];
              end
            end
          end
          `OFS_PDIR: begin
            if (pe_any[2]) begin
              ps_act_q[pe_any[1:0]] <= 1'b0;
              ps_drop_q[pe_any[1:0]] <= 1'b0;
              dist_deact_q <= 1'b1;
              dist_deact_id_q <= pwdata_in[9:0];
            end
          end
          `OFS_STATUS: begin
            if (pwdata_in[`ST_MISS_BIT]) begin
              miss_q <= 1'b0;
            end
          end
          default: begin
            miss_q <= miss_q;
          end
        endcase
      end
      if (done && !pwrite_in && ack_ok_q) begin
        if (paddr_in == `OFS_VACK) begin
          le_q[ack_idx_q][`LE_PEND_BIT] <= 1'b0;
          le_q[ack_idx_q][`LE_ACT_BIT] <= 1'b1;
        end else if (paddr_in == `OFS_PACK) begin
          ps_act_q[ack_idx_q] <= 1'b1;
          ps_drop_q[ack_idx_q] <= 1'b0;
          ps_id_q[ack_idx_q] <= prdata_q[9:0];
          ps_prio_q[ack_idx_q] <= ack_prio_q;
        end
      end
    end
  end

////////////////////////////////////////////////////////////////////////
// Registered outputs

  always @(posedge core_clk_in) begin
    if (!resetn_in) begin
      virt_irq_q <= 1'b0;
      phys_irq_q <= 1'b0;
    end else begin
      virt_irq_q <= vctrl_q[`CTRL_EN_BIT] & vp_found;
      phys_irq_q <= phys_sig;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign virt_irq_out = virt_irq_q;
  assign phys_irq_out = phys_irq_q;
  assign dist_deact_out = dist_deact_q;
  assign dist_deact_id_out = dist_deact_id_q;

endmodule // virq_completion

/* verif/virq_completion_sva.sv */
// Purpose: Port checks for virq_completion
// Assumes: One clock, synchronous active-low reset
// Notes: Entries are internal, so outputs are tied to causes
`timescale 1ns/100ps
module virq_completion_sva (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic phys_irq_req_in,
  input wire logic [4:0] phys_irq_prio_in,
  input wire logic phys_irq_out,
  input wire logic dist_deact_out,
  input wire logic [9:0] dist_deact_id_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_wait:
  assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
    else $error("ready without one wait state");
  chk_ready_single:
  assert property (pready_out |=> !pready_out) else $error("ready too long");
  chk_err_ready:
  assert property (pslverr_out |-> pready_out) else $error("error alone");
  chk_rdata_hold:
  assert property (!(psel_in && penable_in && !pready_out) |=>
    $stable(prdata_out)) else $error("read data moved");
  chk_deact_cause:
  assert property (dist_deact_out |-> $past(pready_out && pwrite_in))
    else $error("deactivate without write");
  chk_deact_single:
  assert property (dist_deact_out |=> !dist_deact_out)
    else $error("deactivate too long");
  chk_deact_id_hold:
  assert property (!dist_deact_out |-> $stable(dist_deact_id_out))
    else $error("deactivate id moved");
  // Priority must beat the idle level, so 0x1F can never be signalled
  chk_pirq_cause:
  assert property (phys_irq_out |-> $past(phys_irq_req_in) &&
    $past(phys_irq_prio_in) < 5'h1F) else $error("phys irq uncaused");
endmodule // virq_completion_sva

bind virq_completion virq_completion_sva virq_completion_sva_i (
  .core_clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .prdata_out,
  .pready_out, .pslverr_out, .phys_irq_req_in, .phys_irq_prio_in,
  .phys_irq_out, .dist_deact_out, .dist_deact_id_out);

/* verif/dist_model.sv */
// Purpose: Distributor stand-in offering one physical interrupt
// Assumes: Bench sets offers, the block sends deactivates
// Notes: Released id and priority lines show inverted values
`timescale 1ns/100ps
module dist_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic offer_in,
  input wire logic [9:0] offer_id_in,
  input wire logic [4:0] offer_prio_in,
  input wire logic deact_in,
  input wire logic [9:0] deact_id_in,
  output logic req_out,
  output logic [9:0] id_out,
  output logic [4:0] prio_out
);
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      req_out <= 1'b0;
      id_out <= 10'h000;
      prio_out <= 5'h00;
    end else if (offer_in) begin
      req_out <= 1'b1;
      id_out <= offer_id_in;
      prio_out <= offer_prio_in;
    end else if (deact_in && deact_id_in == id_out) begin
      req_out <= 1'b0;
      id_out <= ~id_out;
      prio_out <= ~prio_out;
    end
  end
endmodule // dist_model

/* verif/virq_completion_test.sv */
// Purpose: Directed APB tests of virq_completion
// Assumes: One wait state per transfer, four entries
// Notes: Physical slot numbers are checked only through the status read
`timescale 1ns/100ps
`include "virq_defines.vh"
module virq_completion_test;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, offer = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, r;
  logic pready_out, pslverr_out, phys_irq_req_in, phys_irq_out, e;
  logic virt_irq_out, dist_deact_out;
  logic [9:0] phys_irq_id_in, dist_deact_id_out, offer_id = 10'h000;
  logic [4:0] phys_irq_prio_in, offer_prio = 5'h00;
  int n_mismatch = 0, n_compared = 0;
  always #4 core_clk_in = ~core_clk_in;
  virq_completion virq_completion_i (.core_clk_in, .resetn_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
    .pready_out, .pslverr_out, .phys_irq_req_in, .phys_irq_id_in,
    .phys_irq_prio_in, .phys_irq_out, .virt_irq_out, .dist_deact_out,
    .dist_deact_id_out);
  dist_model dist_model_i (.clk_in(core_clk_in), .resetn_in,
    .offer_in(offer), .offer_id_in(offer_id), .offer_prio_in(offer_prio),
    .deact_in(dist_deact_out), .deact_id_in(dist_deact_id_out),
    .req_out(phys_irq_req_in), .id_out(phys_irq_id_in),
    .prio_out(phys_irq_prio_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until pready is seen high; a hang ends the run
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge core_clk_in);
      if (pready_out === 1'b1) break;
      if (i == 19) begin
        n_mismatch++;
        tally_and_finish;
      end
    end
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h00000000);
    ck(nm, r, x);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic dp(input logic p, input logic [9:0] id);
    @(posedge core_clk_in);
    ck("deact", dist_deact_out, p);
    if (p) ck("deact id", dist_deact_id_out, id);
  endtask
  task automatic of(input logic [9:0] id, input logic [4:0] pr);
    @(posedge core_clk_in);
    offer <= 1'b1;
    offer_id <= id;
    offer_prio <= pr;
    @(posedge core_clk_in);
    offer <= 1'b0;
    wt(3);
  endtask
  function automatic logic [31:0] le(logic h, a, p, logic [9:0] pid, vid);
    return {h, 1'b0, a, p, 8'h00, pid, vid};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(10);
    resetn_in <= 1'b1;
    wt(1);
    ck("reset", {phys_irq_out, virt_irq_out, dist_deact_out}, 0);
    rc("le0 reset", `OFS_LE0, 32'h00000000);
    $display("test reset done");
    bus(1'b1, `OFS_VCTRL, 32'h00000001);
    wt(2);
    ck("virq empty", virt_irq_out, 0);
    bus(1'b1, `OFS_LE0, le(1, 1, 1, 10'h055, 10'h021));
    rc("le0 hw", `OFS_LE0, le(1, 1, 0, 10'h055, 10'h021));
    bus(1'b1, `OFS_LE0, le(1, 0, 1, 10'h055, 10'h021));
    wt(2);
    ck("virq listed", virt_irq_out, 1);
    rc("pending st", `OFS_STATUS, 32'h00000002);
    rc("vack", `OFS_VACK, 32'h00000021);
    rc("le0 acked", `OFS_LE0, le(1, 1, 0, 10'h055, 10'h021));
    ck("virq taken", virt_irq_out, 0);
    bus(1'b1, `OFS_VEOI, 32'h00000030);
    rc("le0 kept", `OFS_LE0, le(1, 1, 0, 10'h055, 10'h021));
    rc("miss st", `OFS_STATUS, 32'h00000001);
    bus(1'b1, `OFS_STATUS, 32'h00000001);
    bus(1'b1, `OFS_VEOI, 32'h00000021);
    dp(1'b1, 10'h055);
    rc("le0 done", `OFS_LE0, le(1, 0, 0, 10'h055, 10'h021));
    $display("test virtual done");
    bus(1'b1, `OFS_VCTRL, 32'h00000201);
    bus(1'b1, `OFS_LE3, le(1, 1, 0, 10'h056, 10'h022));
    bus(1'b1, `OFS_VEOI, 32'h00000022);
    dp(1'b0, 10'h000);
    rc("le3 split", `OFS_LE3, le(1, 1, 0, 10'h056, 10'h022));
    bus(1'b1, `OFS_VDIR, 32'h00000022);
    dp(1'b1, 10'h056);
    rc("le3 deact", `OFS_LE3, le(1, 0, 0, 10'h056, 10'h022));
    bus(1'b1, `OFS_VCTRL, 32'h00000001);
    bus(1'b1, `OFS_LE3, le(0, 1, 0, 10'h057, 10'h023));
    bus(1'b1, `OFS_VEOI, 32'h00000023);
    dp(1'b0, 10'h000);
    rc("le3 sw", `OFS_LE3, le(0, 0, 0, 10'h057, 10'h023));
    bus(1'b1, `OFS_LE1, le(0, 0, 1, 10'h058, 10'h024));
    rc("vack le1", `OFS_VACK, 32'h00000024);
    bus(1'b1, `OFS_VAEOI, 32'h00000024);
    dp(1'b0, 10'h000);
    rc("le1 alias", `OFS_LE1, le(0, 0, 0, 10'h058, 10'h024));
    rc("vack none", `OFS_VACK, 32'h000003FF);
    $display("test split done");
    bus(1'b1, `OFS_PCTRL, 32'h00000201);
    of(10'h040, 5'h04);
    ck("pirq up", phys_irq_out, 1);
    rc("pack", `OFS_PACK, 32'h00000040);
    of(10'h041, 5'h06);
    ck("pirq gated", phys_irq_out, 0);
    bus(1'b1, `OFS_PEOI, 32'h00000040);
    dp(1'b0, 10'h000);
    rc("drop st", `OFS_STATUS, 32'h00000110);
    wt(2);
    ck("pirq dropped", phys_irq_out, 1);
    of(10'h040, 5'h04);
    ck("pirq active", phys_irq_out, 0);
    bus(1'b1, `OFS_PDIR, 32'h00000040);
    dp(1'b1, 10'h040);
    of(10'h040, 5'h04);
    ck("pirq freed", phys_irq_out, 1);
    bus(1'b1, `OFS_PCTRL, 32'h00000001);
    rc("pack nosplit", `OFS_PACK, 32'h00000040);
    bus(1'b1, `OFS_PAEOI, 32'h00000040);
    dp(1'b1, 10'h040);
    rc("pack gone", `OFS_PACK, 32'h000003FF);
    $display("test physical done");
    bus(1'b0, 12'hFFC, 32'h00000000);
    ck("slverr", e, 1);
    $display("test unmapped done");
    tally_and_finish;
  end
endmodule // virq_completion_test
